//--- tscp_pkg.sv
// constants shared by the thermometer serial command port
package tscp_pkg;
    // value is arbitrary
    localparam logic [3:0] FIXED_ADDR_CODE = 4'h6;
    localparam logic [7:0] CMD_START_CONV  = 8'h51;
    localparam logic [7:0] CMD_STOP_CONV   = 8'h22;
    localparam logic [7:0] CMD_READ_TEMP   = 8'haa;
    localparam logic [7:0] CMD_HIGH_TRIP   = 8'ha1;
    localparam logic [7:0] CMD_LOW_TRIP    = 8'ha2;
    localparam logic [7:0] CMD_CONFIG      = 8'hac;
    localparam logic [7:0] CMD_SOFT_POR    = 8'h54;
    localparam logic [15:0] HIGH_TRIP_RESET = 16'h0000;
    localparam logic [15:0] LOW_TRIP_RESET  = 16'h0000;
    localparam logic [7:0]  CONFIG_RESET    = 8'h0c;
    localparam int CONFIG_ONESHOT_BIT = 0;
    localparam logic [3:0] BIT_COUNT_LAST  = 4'h7;
    localparam logic [3:0] BIT_COUNT_ACK   = 4'h8;
    typedef enum logic [1:0] {
        TSCP_SEL_TEMP = 2'h0,
        TSCP_SEL_HIGH = 2'h1,
        TSCP_SEL_LOW  = 2'h2,
        TSCP_SEL_CFG  = 2'h3
    } tscp_sel_t;
endpackage : tscp_pkg

//--- tscp_sync.sv
// two-flop synchroniser with edge outputs taken from the second stage
module tscp_sync (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic asyncIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // reset high: an idle bus line is high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule : tscp_sync

//--- tscp_port.sv
// slave side two-wire command port of a thermometer / thermostat
// Overview of operation
// - bytes go over the data line most significant bit first.
// - one data bit per serial clock period.
// - idle bus has data and clock both high, data pulled up.
// - data changes only while clock low, except start and stop.
// - each byte is followed by one acknowledge clock, nine clocks total.
// - device acknowledges matching control byte and the command byte.
// - writes: one config byte or two threshold bytes, each acknowledged.
// - device drives data from the clock right after read acknowledge.
// - config read is one byte, master answers nack then stop.
// - two-byte reads: master acks first, nacks second; second only after ack.
// - master may nack after first byte; device then stops driving.
// - command 51h starts conversions, single or continuous per mode bit.
// - command 22h halts continuous conversions.
// - command AAh selects the two-byte temperature result for reading.
// - commands A1h and A2h select the high and low trip thresholds.
// - command ACh selects the one-byte configuration register.
// - command 54h resets every register, the run flag and the protocol state to power-up; here the bit counter and the ack drive run on.
// - address is fixed four-bit code plus three select pins.
// - acknowledge holds data low a whole period; transmitter releases line.
module tscp_port (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic        address_select_bit2,
    input  wire logic        address_select_bit1,
    input  wire logic        address_select_bit0,
    input  wire logic [15:0] temperature,
    output logic             convertRun,
    output logic             single_conversion_mode,
    output logic [15:0]      high_trip_threshold,
    output logic [15:0]      low_trip_threshold,
    output logic [7:0]       configReg,
    output logic             softResetPulse
);
    typedef enum logic [5:0] {
        TSCP_IDLE = 6'b000001,
        TSCP_ADDR = 6'b000010,
        TSCP_CMD  = 6'b000100,
        TSCP_WR   = 6'b001000,
        TSCP_RD   = 6'b010000,
        TSCP_SKIP = 6'b100000
    } tscp_state_t;

    logic        scl;
    logic        sclRise;
    logic        sclFall;
    logic        sda;
    logic        sdaRise;
    logic        sdaFall;
    logic        startCond;
    logic        stopCond;
    tscp_state_t state_q;
    logic [3:0]  bitCnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  txByte_q;
    logic        ackDrive_q;
    logic        ackNext_q;
    logic        txDrive_q;
    logic        isRead_q;
    logic        byteIdx_q;
    logic        masterNack_q;
    tscp_pkg::tscp_sel_t sel_q;
    logic        runFlag_q;
    logic [15:0] high_q;
    logic [15:0] low_q;
    logic [7:0]  cfg_q;
    logic        soft_q;
    logic [7:0]  rxByte;
    logic        byteDone;
    logic        addrMatch;

    tscp_sync u_scl_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn (sclIn),
        .level   (scl),
        .rise    (sclRise),
        .fall    (sclFall)
    );

    tscp_sync u_sda_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn (sdaIn),
        .level   (sda),
        .rise    (sdaRise),
        .fall    (sdaFall)
    );

    // data edges while clock high are bus conditions
    assign startCond = sdaFall & scl;
    assign stopCond  = sdaRise & scl;

    // byte fetch for a selected read, msb byte first
    function automatic logic [7:0] readByte(input tscp_pkg::tscp_sel_t sel,
                                            input logic idx,
                                            input logic [15:0] t,
                                            input logic [15:0] h,
                                            input logic [15:0] l,
                                            input logic [7:0] c);
        logic [15:0] w;
        w = t;
        case (sel)
            tscp_pkg::TSCP_SEL_HIGH: w = h;
            tscp_pkg::TSCP_SEL_LOW:  w = l;
            tscp_pkg::TSCP_SEL_CFG:  w = {c, 8'h00};
            default:       w = t;
        endcase
        readByte = idx ? w[7:0] : w[15:8];
    endfunction : readByte

    // incoming bit sampled on clock rise, msb first
    assign rxByte    = {shift_q[6:0], sda};
    assign byteDone  = sclRise && (bitCnt_q == tscp_pkg::BIT_COUNT_LAST);
    assign addrMatch = rxByte[7:4] == tscp_pkg::FIXED_ADDR_CODE
        && rxByte[3:1] == {address_select_bit2, address_select_bit1,
                           address_select_bit0};

    // bit counter: eight data clocks then the ack clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q <= 4'h0;
            shift_q  <= 8'h00;
        end else if (startCond) begin
            // one below zero: the clock fall that closes start wraps to zero
            bitCnt_q <= 4'hf;
        end else if (stopCond) begin
            bitCnt_q <= 4'h0;
        end else if (sclRise) begin
            shift_q <= rxByte;
        end else if (sclFall) begin
            if (bitCnt_q == tscp_pkg::BIT_COUNT_ACK) begin
                bitCnt_q <= 4'h0;
            end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
            end
        end
    end

    // protocol state machine
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= TSCP_IDLE;
            isRead_q     <= 1'b0;
            byteIdx_q    <= 1'b0;
            masterNack_q <= 1'b0;
            sel_q        <= tscp_pkg::TSCP_SEL_TEMP;
        end else if (soft_q) begin
            state_q <= TSCP_IDLE;
            sel_q   <= tscp_pkg::TSCP_SEL_TEMP;
        end else if (startCond) begin
            state_q      <= TSCP_ADDR;
            byteIdx_q    <= 1'b0;
            masterNack_q <= 1'b0;
        end else if (stopCond) begin
            state_q <= TSCP_IDLE;
        end else if (byteDone) begin
            case (state_q)
                TSCP_ADDR: begin
                    if (!addrMatch) begin
                        state_q <= TSCP_SKIP;
                    end else if (rxByte[0]) begin
                        state_q  <= TSCP_RD;
                        isRead_q <= 1'b1;
                    end else begin
                        state_q  <= TSCP_CMD;
                        isRead_q <= 1'b0;
                    end
                end
                TSCP_CMD: begin
                    state_q <= TSCP_WR;
                    case (rxByte)
                        tscp_pkg::CMD_READ_TEMP:
                            sel_q <= tscp_pkg::TSCP_SEL_TEMP;
                        tscp_pkg::CMD_HIGH_TRIP:
                            sel_q <= tscp_pkg::TSCP_SEL_HIGH;
                        tscp_pkg::CMD_LOW_TRIP:
                            sel_q <= tscp_pkg::TSCP_SEL_LOW;
                        tscp_pkg::CMD_CONFIG:
                            sel_q <= tscp_pkg::TSCP_SEL_CFG;
                        default: sel_q <= sel_q;
                    endcase
                end
                TSCP_WR: byteIdx_q <= 1'b1;
                default: state_q <= state_q;
            endcase
        end else if (state_q == TSCP_RD && sclRise && !ackDrive_q
                     && bitCnt_q == tscp_pkg::BIT_COUNT_ACK) begin
            // master ack picks the next byte, nack ends the read; our own
            // ack of the read control byte is not an answer from the master
            if (sda || byteIdx_q
                || sel_q == tscp_pkg::TSCP_SEL_CFG) begin
                masterNack_q <= 1'b1;
            end else begin
                byteIdx_q <= 1'b1;
            end
        end
    end

    // data line drive: ack slot and read data, set only on clock fall, also cleared by start or stop;
    // a soft reset must not cut the ack of its own command byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ackDrive_q <= 1'b0;
            ackNext_q  <= 1'b0;
            txDrive_q  <= 1'b0;
            txByte_q   <= 8'h00;
        end else if (startCond || stopCond) begin
            ackDrive_q <= 1'b0;
            ackNext_q  <= 1'b0;
            txDrive_q  <= 1'b0;
        end else if (byteDone) begin
            // decided on the last bit, before the state moves on
            ackNext_q <= (state_q == TSCP_ADDR && addrMatch)
                || state_q == TSCP_CMD || state_q == TSCP_WR;
        end else if (sclFall) begin
            ackDrive_q <= 1'b0;
            txDrive_q  <= 1'b0;
            if (bitCnt_q == tscp_pkg::BIT_COUNT_LAST) begin
                ackDrive_q <= ackNext_q;
            end else if (bitCnt_q == tscp_pkg::BIT_COUNT_ACK) begin
                // first data bit follows the ack clock directly
                if (state_q == TSCP_RD && isRead_q && !masterNack_q) begin
                    txDrive_q <= 1'b1;
                    txByte_q  <= readByte(sel_q, byteIdx_q, temperature,
                                          high_q, low_q, cfg_q);
                end
            end else if (state_q == TSCP_RD && txDrive_q) begin
                txDrive_q <= bitCnt_q < 4'h7;
                txByte_q  <= {txByte_q[6:0], 1'b0};
            end
        end
    end

    // the read slave releases the line during the master ack clock
    assign sdaOut = 1'b0;
    assign sdaOe  = ackDrive_q | (txDrive_q & ~txByte_q[7]);

    // register writes and command effects
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_q    <= tscp_pkg::HIGH_TRIP_RESET;
            low_q     <= tscp_pkg::LOW_TRIP_RESET;
            cfg_q     <= tscp_pkg::CONFIG_RESET;
            runFlag_q <= 1'b0;
            soft_q    <= 1'b0;
        end else if (soft_q) begin
            high_q    <= tscp_pkg::HIGH_TRIP_RESET;
            low_q     <= tscp_pkg::LOW_TRIP_RESET;
            cfg_q     <= tscp_pkg::CONFIG_RESET;
            runFlag_q <= 1'b0;
            soft_q    <= 1'b0;
        end else if (byteDone && state_q == TSCP_CMD) begin
            case (rxByte)
                tscp_pkg::CMD_START_CONV: runFlag_q <= 1'b1;
                tscp_pkg::CMD_STOP_CONV: begin
                    // single mode ends on its own, so only continuous halts
                    if (!cfg_q[tscp_pkg::CONFIG_ONESHOT_BIT]) begin
                        runFlag_q <= 1'b0;
                    end
                end
                tscp_pkg::CMD_SOFT_POR: soft_q <= 1'b1;
                default: runFlag_q <= runFlag_q;
            endcase
        end else if (byteDone && state_q == TSCP_WR) begin
            case (sel_q)
                tscp_pkg::TSCP_SEL_CFG: begin
                    if (!byteIdx_q) begin
                        cfg_q <= rxByte;
                    end
                end
                tscp_pkg::TSCP_SEL_HIGH: begin
                    if (byteIdx_q) begin
                        high_q[7:0] <= rxByte;
                    end else begin
                        high_q[15:8] <= rxByte;
                    end
                end
                tscp_pkg::TSCP_SEL_LOW: begin
                    if (byteIdx_q) begin
                        low_q[7:0] <= rxByte;
                    end else begin
                        low_q[15:8] <= rxByte;
                    end
                end
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    assign convertRun             = runFlag_q;
    assign single_conversion_mode = cfg_q[tscp_pkg::CONFIG_ONESHOT_BIT];
    assign high_trip_threshold    = high_q;
    assign low_trip_threshold     = low_q;
    assign configReg              = cfg_q;
    assign softResetPulse         = soft_q;
endmodule : tscp_port

//--- tscp_port_properties.sv
// concurrent checks on the command port pins and register outputs
module tscp_port_properties (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        sclIn,
    input wire logic        sdaOe,
    input wire logic        convertRun,
    input wire logic        single_conversion_mode,
    input wire logic [15:0] high_trip_threshold,
    input wire logic [15:0] low_trip_threshold,
    input wire logic [7:0]  configReg,
    input wire logic        softResetPulse
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    AST_SOFT_RST: assert property (softResetPulse |-> ##[0:4]
        (configReg == tscp_pkg::CONFIG_RESET && !convertRun))
        else $error("soft reset left state behind");
    AST_PULSE_ONE: assert property (softResetPulse |=> !softResetPulse)
        else $error("soft reset pulse too long");
    // conversions only halt in continuous mode or through a soft reset
    AST_MODE_BIT: assert property ($fell(convertRun) |->
        !$past(single_conversion_mode) || $past(softResetPulse))
        else $error("conversions halted in single mode");
    // drive may only move while the clock pin is low
    AST_OE_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data drive changed with clock high");
    AST_BIT_HOLD: assert property ($rose(sdaOe) |-> sdaOe[*6])
        else $error("driven low bit too short");
    AST_IDLE_FREE: assert property (sclIn[*8] |-> !sdaOe)
        else $error("data driven on idle bus");
    AST_RUN_ACK: assert property ($rose(convertRun) |-> ##[0:8] sdaOe)
        else $error("conversion start without acknowledge");
    AST_HIGH_ACK: assert property ($changed(high_trip_threshold) &&
        high_trip_threshold != tscp_pkg::HIGH_TRIP_RESET |-> ##[0:8] sdaOe)
        else $error("high threshold written without acknowledge");
    AST_LOW_ACK: assert property ($changed(low_trip_threshold) &&
        low_trip_threshold != tscp_pkg::LOW_TRIP_RESET |-> ##[0:8] sdaOe)
        else $error("low threshold written without acknowledge");
    AST_CFG_ACK: assert property ($changed(configReg) &&
        configReg != tscp_pkg::CONFIG_RESET |-> ##[0:8] sdaOe)
        else $error("config written without acknowledge");
    C_POR: cover property (softResetPulse);
    C_RUN: cover property ($rose(convertRun));
    C_CFG: cover property ($changed(configReg));
endmodule : tscp_port_properties

bind tscp_port tscp_port_properties u_chk (.ref_clk, .reset_n, .sclIn,
    .sdaOe, .convertRun, .single_conversion_mode, .high_trip_threshold,
    .low_trip_threshold, .configReg, .softResetPulse);

//--- tscp_master_model.sv
// two-wire bus master model driving clock and pulling data low
module tscp_master_model (
    input  wire logic ref_clk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : w
    task automatic start();
        sdaPull = 1'b0;
        // let the slave drop its ack before the clock rises, else a stop
        w(4);
        scl = 1'b1;
        w(4);
        sdaPull = 1'b1;
        w(4);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        w(2);
        sdaPull = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sdaPull = 1'b0;
        w(4);
    endtask : stop
    // nine clocks of 8 ref periods; tx[0] is the acknowledge slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            w(2);
            sdaPull = !tx[i];
            w(2);
            scl = 1'b1;
            w(4);
            rx[i] = sdaLine;
            scl = 1'b0;
        end
    endtask : xfer
endmodule : tscp_master_model

//--- tb_tscp_port.sv
// self-checking bench for the thermometer command port
module tb_tscp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk;
    logic        reset_n;
    logic [2:0]  aSel;
    logic [15:0] temp;
    logic        scl;
    logic        sdaPull;
    logic        sdaOut;
    logic        sdaOe;
    logic        run;
    logic        single;
    logic [15:0] hiT;
    logic [15:0] loT;
    logic [7:0]  cfg;
    logic        por;
    logic [8:0]  r;
    int          fail_count = 0;
    int          check_count = 0;
    int          porSeen = 0;
    // open drain: the device only pulls low when it drives a zero
    wire         sdaLine = !sdaPull && !(sdaOe && !sdaOut);
    tscp_port uut (.ref_clk, .reset_n, .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut, .sdaOe, .address_select_bit2(aSel[2]),
        .address_select_bit1(aSel[1]), .address_select_bit0(aSel[0]),
        .temperature(temp), .convertRun(run),
        .single_conversion_mode(single), .high_trip_threshold(hiT),
        .low_trip_threshold(loT), .configReg(cfg), .softResetPulse(por));
    tscp_master_model mst (.ref_clk, .sdaLine, .scl, .sdaPull);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (por === 1'b1) porSeen++;
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic ctl(input logic rw);
        mst.start();
        mst.xfer({tscp_pkg::FIXED_ADDR_CODE, aSel, rw, 1'b1}, r);
        chk("ctrl ack", 16'h0000, {15'h0000, r[0]});
    endtask : ctl
    task automatic wr(input logic [7:0] d);
        mst.xfer({d, 1'b1}, r);
        chk("byte ack", 16'h0000, {15'h0000, r[0]});
    endtask : wr
    task automatic cmd(input logic [7:0] c);
        ctl(1'b0);
        wr(c);
    endtask : cmd
    task automatic t_write();
        cmd(tscp_pkg::CMD_HIGH_TRIP);
        wr(8'h28);
        wr(8'h00);
        mst.stop();
        chk("high", 16'h2800, hiT);
        cmd(tscp_pkg::CMD_LOW_TRIP);
        wr(8'h0a);
        wr(8'h00);
        mst.stop();
        chk("low", 16'h0a00, loT);
        cmd(tscp_pkg::CMD_CONFIG);
        wr(8'h02);
        mst.stop();
        chk("cfg", 16'h0002, {8'h00, cfg});
        $display("t_write done");
    endtask : t_write
    task automatic t_read();
        logic [7:0]  c [3] = '{8'haa, 8'ha1, 8'ha2};
        logic [15:0] e [3] = '{16'h1970, 16'h2800, 16'h0a00};
        logic [15:0] d;
        temp = 16'h1970;
        for (int i = 0; i < 3; i++) begin
            cmd(c[i]);
            ctl(1'b1);
            mst.xfer({8'hff, 1'b0}, r);
            d[15:8] = r[8:1];
            mst.xfer({8'hff, 1'b1}, r);
            d[7:0] = r[8:1];
            mst.stop();
            chk("read16", e[i], d);
        end
        $display("t_read done");
    endtask : t_read
    task automatic t_short();
        logic [7:0] c [2] = '{8'hac, 8'ha1};
        logic [7:0] e [2] = '{8'h02, 8'h28};
        for (int i = 0; i < 2; i++) begin
            cmd(c[i]);
            ctl(1'b1);
            mst.xfer({8'hff, 1'b1}, r);
            chk("read8", {8'h00, e[i]}, {8'h00, r[8:1]});
            mst.w(4);
            chk("released", 16'h0000, {15'h0000, sdaOe});
            mst.stop();
        end
        $display("t_short done");
    endtask : t_short
    task automatic t_conv();
        logic [7:0] m [2] = '{8'h02, 8'h01};
        for (int i = 0; i < 2; i++) begin
            cmd(tscp_pkg::CMD_CONFIG);
            wr(m[i]);
            mst.stop();
            chk("mode", 16'(i), {15'h0000, single});
            cmd(tscp_pkg::CMD_START_CONV);
            mst.stop();
            chk("run on", 16'h0001, {15'h0000, run});
            cmd(tscp_pkg::CMD_STOP_CONV);
            mst.stop();
            chk("run off", 16'(i), {15'h0000, run});
        end
        $display("t_conv done");
    endtask : t_conv
    task automatic t_por();
        int p0;
        p0 = porSeen;
        cmd(tscp_pkg::CMD_SOFT_POR);
        mst.stop();
        chk("pulses", 16'h0001, 16'(porSeen - p0));
        chk("cfg", {8'h00, tscp_pkg::CONFIG_RESET}, {8'h00, cfg});
        chk("high", tscp_pkg::HIGH_TRIP_RESET, hiT);
        chk("low", tscp_pkg::LOW_TRIP_RESET, loT);
        chk("run", 16'h0000, {15'h0000, run});
        $display("t_por done");
    endtask : t_por
    task automatic t_addr();
        aSel = 3'h5;
        cmd(tscp_pkg::CMD_CONFIG);
        wr(8'h5a);
        mst.stop();
        chk("cfg", 16'h005a, {8'h00, cfg});
        mst.start();
        mst.xfer({8'h90, 1'b1}, r);
        chk("foreign", 16'h0001, {15'h0000, r[0]});
        mst.xfer({tscp_pkg::CMD_HIGH_TRIP, 1'b1}, r);
        chk("ignored", 16'h0001, {15'h0000, r[0]});
        mst.xfer({8'h77, 1'b1}, r);
        mst.stop();
        chk("high", 16'h0000, hiT);
        chk("idle", 16'h0001, {15'h0000, sdaLine});
        aSel = 3'h0;
        $display("t_addr done");
    endtask : t_addr
    task automatic t_reset();
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("rst cfg", {8'h00, tscp_pkg::CONFIG_RESET}, {8'h00, cfg});
        chk("rst oe", 16'h0000, {15'h0000, sdaOe});
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmd(tscp_pkg::CMD_CONFIG);
        ctl(1'b1);
        mst.xfer({8'hff, 1'b1}, r);
        mst.stop();
        chk("rst rd", {8'h00, tscp_pkg::CONFIG_RESET}, {8'h00, r[8:1]});
        $display("t_reset done");
    endtask : t_reset
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        #2ms;
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        aSel = 3'h0;
        temp = 16'h0000;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_write();
        t_read();
        t_short();
        t_conv();
        t_por();
        t_addr();
        t_reset();
        test_done();
    end
endmodule : tb_tscp_port
